// ==== core/register_write_command_exec.v ====
// register-write command family executor
// assumes decoded command words arrive on one clock with cmd_valid
// and that the register file and program buffer sit outside
// and that exec_busy, cmd_src and cmd_data share the same clock
// and that the host framer builds its reply from ack and nak
//
// Summary of operation
// - the word patch copies the low 16 register bits into a buffer word.
// - the word patch is command 139, three words, taken from either thread.
// - the patched value is stored unchecked, whatever its range.
// - the register file property write decodes exactly as command 154.
// - the immediate write stores its data and is allowed at any time.
// - the program-mode write from serial is rejected while busy.
// - the program-mode write is command 154, four words, either thread.
// - the 32-bit data is taken as raw bits, signed or unsigned alike.
// - the extended modify is command 30, five words, either thread.
// - the extended modify does or, clear, and, xor or add by opcode.
`timescale 1ns/1ps
`include "regwr_defs.vh"
module register_write_command_exec
#(
   parameter DATA_W = `DATA_W,
   parameter WORD_W = `WORD_W,
   parameter RADDR_W = 16,
   parameter PADDR_W = 16
)
(
   clk,
   rstn,
   // command in
   cmd_valid,
   cmd_ready,
   cmd_src,
   cmd_thread,
   cmd_num,
   cmd_op,
   cmd_reg,
   cmd_loc,
   cmd_data,
   exec_busy,
   // register file side
   rf_rd_addr,
   rf_rd_data,
   rf_wr_en,
   rf_wr_addr,
   rf_wr_data,
   // program buffer side
   pb_wr_en,
   pb_wr_addr,
   pb_wr_data,
   // host answer
   ack,
   nak
);
   input wire clk;
   input wire rstn;

   // command in
   input wire cmd_valid;
   output wire cmd_ready;
   input wire cmd_src;
   input wire cmd_thread;
   input wire [7:0] cmd_num;
   input wire [2:0] cmd_op;
   input wire [RADDR_W-1:0] cmd_reg;
   input wire [PADDR_W-1:0] cmd_loc;
   input wire [DATA_W-1:0] cmd_data;
   input wire exec_busy;

   // register file side
   output wire [RADDR_W-1:0] rf_rd_addr;
   input wire [DATA_W-1:0] rf_rd_data;
   output reg rf_wr_en;
   output reg [RADDR_W-1:0] rf_wr_addr;
   output reg [DATA_W-1:0] rf_wr_data;

   // program buffer side
   output reg pb_wr_en;
   output reg [PADDR_W-1:0] pb_wr_addr;
   output reg [WORD_W-1:0] pb_wr_data;

   // host answer
   output wire ack;
   output wire nak;

   ////////////////////////////////////////////////////////////////////
   localparam [7:0] NUM_IMM = `CMD_IMM_WRITE;
   localparam [7:0] NUM_MOD = `CMD_EXT_MODIFY;
   localparam [7:0] NUM_PATCH = `CMD_WORD_PATCH;
   localparam [7:0] NUM_PROG = `CMD_PROG_WRITE;
   localparam [2:0] FAM_NONE = 3'h0;
   localparam [2:0] FAM_IMM = 3'h1;
   localparam [2:0] FAM_PROG = 3'h2;
   localparam [2:0] FAM_MOD = 3'h3;
   localparam [2:0] FAM_PATCH = 3'h4;

   wire [DATA_W-1:0] alu_res;
   wire alu_ok;
   wire hit_imm;
   wire hit_mod;
   wire hit_patch;
   wire hit_prog;
   wire from_serial;
   wire prog_refused;
   wire rf_go;
   wire pb_go;
   wire [WORD_W-1:0] low_word;
   reg [2:0] fam;
   reg done_r;
   reg ok_r;
   reg do_rf;
   reg do_pb;
   reg ok_nxt;
   reg [DATA_W-1:0] wdata;

   // single-cycle execution, never stalls
   assign cmd_ready = 1'b1;
   // combinational read port; thread id needs no special handling
   assign rf_rd_addr = cmd_reg;

   ////////////////////////////////////////////////////////////////////
   // one hit line per command family
   assign hit_imm = (cmd_num == NUM_IMM);
   assign hit_mod = (cmd_num == NUM_MOD);
   assign hit_patch = (cmd_num == NUM_PATCH);
   // property and program writes share one number
   assign hit_prog = (cmd_num == NUM_PROG);

   // serial copy refused while a program runs
   assign from_serial = (cmd_src == `SRC_SERIAL);
   assign prog_refused = from_serial & exec_busy;

   // family code first, so the action table stays one flat case
   always @*
   begin
      fam = FAM_NONE;
      if (hit_imm)
      begin
         fam = FAM_IMM;
      end
      else if (hit_prog)
      begin
         fam = FAM_PROG;
      end
      else if (hit_mod)
      begin
         fam = FAM_MOD;
      end
      else if (hit_patch)
      begin
         fam = FAM_PATCH;
      end
   end

   ////////////////////////////////////////////////////////////////////
   reg_modify_alu #(.W(DATA_W)) u_alu
   (
      .op(cmd_op),
      .old_val(rf_rd_data),
      .operand(cmd_data),
      .result(alu_res),
      .op_ok(alu_ok)
   );

   ////////////////////////////////////////////////////////////////////
   always @*
   begin
      do_rf = 1'b0;
      do_pb = 1'b0;
      ok_nxt = 1'b0;
      // raw bit pattern, no sign handling
      wdata = cmd_data;
      case (fam)
         // immediate write, allowed at any time
         FAM_IMM:
         begin
            do_rf = 1'b1;
            ok_nxt = 1'b1;
         end
         FAM_PROG:
         begin
            do_rf = ~prog_refused;
            ok_nxt = ~prog_refused;
         end
         FAM_MOD:
         begin
            wdata = alu_res;
            do_rf = alu_ok;
            ok_nxt = alu_ok;
         end
         FAM_PATCH:
         begin
            do_pb = 1'b1;
            ok_nxt = 1'b1;
         end
         // unknown numbers come back as a reject
         default:
         begin
            do_rf = 1'b0;
            do_pb = 1'b0;
            ok_nxt = 1'b0;
         end
      endcase
   end

   assign rf_go = cmd_valid & do_rf;
   assign pb_go = cmd_valid & do_pb;
   // low word taken as is, range is the program's concern
   assign low_word = rf_rd_data[WORD_W-1:0];

   ////////////////////////////////////////////////////////////////////
   // register file strobe, one cycle per taken write
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rf_wr_en <= 1'b0;
      end
      else
      begin
         rf_wr_en <= rf_go;
      end
   end

   // address and data hold until the next write
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rf_wr_addr <= {RADDR_W{1'b0}};
         rf_wr_data <= {DATA_W{1'b0}};
      end
      else if (rf_go)
      begin
         rf_wr_addr <= cmd_reg;
         rf_wr_data <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // program buffer strobe
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pb_wr_en <= 1'b0;
      end
      else
      begin
         pb_wr_en <= pb_go;
      end
   end

   // patched word holds until the next patch
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pb_wr_addr <= {PADDR_W{1'b0}};
         pb_wr_data <= {WORD_W{1'b0}};
      end
      else if (pb_go)
      begin
         pb_wr_addr <= cmd_loc;
         pb_wr_data <= low_word;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // completion flag, set in the same cycle as the strobes
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= cmd_valid;
      end
   end

   // outcome kept beside done_r; ignored when nothing was taken
   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ok_r <= 1'b0;
      end
      else
      begin
         ok_r <= ok_nxt;
      end
   end

   ack_pulse u_ack
   (
      .clk(clk),
      .rstn(rstn),
      .done(done_r),
      .ok(ok_r),
      .ack(ack),
      .nak(nak)
   );
endmodule // register_write_command_exec

// ==== core/regwr_defs.vh ====
// command numbers, opcodes and layout constants for the register-write
// command executor; definitions only
`ifndef REGWR_DEFS_VH
`define REGWR_DEFS_VH
`define CMD_IMM_WRITE 8'h0B
`define CMD_EXT_MODIFY 8'h1E
`define CMD_WORD_PATCH 8'h8B
`define CMD_PROG_WRITE 8'h9A
`define OP_SET 3'h0
`define OP_CLEAR 3'h1
`define OP_AND 3'h2
`define OP_XOR 3'h3
`define OP_ADD 3'h4
`define DATA_W 32
`define WORD_W 16
`define SRC_SERIAL 1'b0
`define SRC_PROGRAM 1'b1
`endif

// ==== core/reg_modify_alu.v ====
// read-modify-write arithmetic for the extended register modify command
// assumes old value and operand are stable in the same cycle
`timescale 1ns/1ps
`include "regwr_defs.vh"
module reg_modify_alu
#(
   parameter W = 32
)
(
   op,
   old_val,
   operand,
   result,
   op_ok
);
   input wire [2:0] op;
   input wire [W-1:0] old_val;
   input wire [W-1:0] operand;
   output reg [W-1:0] result;
   output reg op_ok;

   always @*
   begin
      result = old_val;
      op_ok = 1'b1;
      case (op)
         `OP_SET: result = old_val | operand;
         `OP_CLEAR: result = old_val & ~operand;
         `OP_AND: result = old_val & operand;
         `OP_XOR: result = old_val ^ operand;
         // wraps modulo 2^W, same for signed and unsigned
         `OP_ADD: result = old_val + operand;
         default: op_ok = 1'b0;
      endcase
   end
endmodule // reg_modify_alu

// ==== core/ack_pulse.v ====
// one-cycle acknowledge / reject indication toward the host framer
// assumes done and ok come from the same clock domain
`timescale 1ns/1ps
module ack_pulse
(
   clk,
   rstn,
   done,
   ok,
   ack,
   nak
);
   input wire clk;
   input wire rstn;
   input wire done;
   input wire ok;
   output reg ack;
   output reg nak;

   always @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack <= 1'b0;
         nak <= 1'b0;
      end
      else
      begin
         ack <= done & ok;
         nak <= done & ~ok;
      end
   end
endmodule // ack_pulse

// ==== verif/rf_model.sv ====
// register file beside the executor
// assumes only the low four address bits matter
`timescale 1ns/1ps
module rf_model
(
   input wire clk,
   input wire [15:0] rf_rd_addr,
   output wire [31:0] rf_rd_data,
   input wire rf_wr_en,
   input wire [15:0] rf_wr_addr,
   input wire [31:0] rf_wr_data
);
   logic [31:0] mem [0:15] = '{default: 32'h0};
   assign rf_rd_data = mem[rf_rd_addr[3:0]];
   always @(posedge clk)
   begin
      if (rf_wr_en)
         mem[rf_wr_addr[3:0]] <= rf_wr_data;
   end
endmodule // rf_model

// ==== verif/register_write_command_exec_sva.sv ====
// port checks for the executor
// assumes one clock, async low reset
`timescale 1ns/1ps
module register_write_command_exec_sva
(
   input wire clk,
   input wire rstn,
   input wire cmd_valid,
   input wire cmd_src,
   input wire [7:0] cmd_num,
   input wire [2:0] cmd_op,
   input wire [31:0] cmd_data,
   input wire exec_busy,
   input wire [31:0] rf_rd_data,
   input wire rf_wr_en,
   input wire [31:0] rf_wr_data,
   input wire pb_wr_en,
   input wire [15:0] pb_wr_data,
   input wire ack,
   input wire nak
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire c_pat = cmd_valid && cmd_num == 8'h8B;
   wire c_prg = cmd_valid && cmd_num == 8'h9A;
   wire c_mod = cmd_valid && cmd_num == 8'h1E;
   a_patch_low: assert property (c_pat |=>
      pb_wr_en && pb_wr_data == $past(rf_rd_data[15:0])) else $error("pb");
   a_patch_ack: assert property (c_pat |-> ##2 ack && !nak)
      else $error("ack");
   a_imm_store: assert property (cmd_valid && cmd_num == 8'h0B |=>
      rf_wr_en && rf_wr_data == $past(cmd_data)) else $error("imm");
   a_prog_reject: assert property (c_prg && !cmd_src && exec_busy |=>
      !rf_wr_en ##1 nak) else $error("rej");
   a_prog_take: assert property (c_prg && (cmd_src || !exec_busy) |=>
      rf_wr_en ##1 ack) else $error("prg");
   a_mod_add: assert property (c_mod && cmd_op == 3'h4 |=>
      rf_wr_data == $past(rf_rd_data) + $past(cmd_data)) else $error("add");
   a_mod_clear: assert property (c_mod && cmd_op == 3'h1 |=>
      rf_wr_data == ($past(rf_rd_data) & ~$past(cmd_data))) else $error("clr");
   a_mod_badop: assert property (c_mod && cmd_op > 3'h4 |=>
      !rf_wr_en ##1 nak && !ack) else $error("op");
   cover property (c_pat);
   cover property (c_mod && cmd_op == 3'h3);
   cover property (nak);
   cover property (c_prg && !cmd_src && exec_busy);
endmodule // register_write_command_exec_sva

// ==== verif/test_register_write_command_exec.sv ====
// self-checking bench for the executor
// assumes rf_model answers register reads
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   n_mismatch++; $display("unexpected at %0t: mismatch", $time); end end
module test_register_write_command_exec;
   logic clk = 0, rstn = 0, cmd_valid = 0, cmd_src = 0, cmd_thread = 0;
   logic exec_busy = 0, cmd_ready, rf_wr_en, pb_wr_en, ack, nak, w, p, a, n;
   logic [7:0] cmd_num = 8'h00;
   logic [2:0] cmd_op = 3'h0;
   logic [15:0] cmd_reg = 16'h0, cmd_loc = 16'h0, rf_rd_addr, rf_wr_addr;
   logic [15:0] pb_wr_addr, pb_wr_data;
   logic [31:0] cmd_data = 32'h0, rf_rd_data, rf_wr_data;
   int n_mismatch = 0, samples_checked = 0;
   register_write_command_exec dut (.clk, .rstn, .cmd_valid, .cmd_ready,
      .cmd_src, .cmd_thread, .cmd_num, .cmd_op, .cmd_reg, .cmd_loc,
      .cmd_data, .exec_busy, .rf_rd_addr, .rf_rd_data, .rf_wr_en,
      .rf_wr_addr, .rf_wr_data, .pb_wr_en, .pb_wr_addr, .pb_wr_data,
      .ack, .nak);
   rf_model u_rf (.clk, .rf_rd_addr, .rf_rd_data, .rf_wr_en, .rf_wr_addr,
      .rf_wr_data);
   ////////////////////////////////////////////////////////////
   task issue(input [7:0] nm, input [15:0] r, input [31:0] d,
      input [1:0] sb = 2'h0, input [2:0] o = 3'h0, input [15:0] l = 16'h0);
      @(posedge clk);
      {cmd_valid, cmd_num, cmd_reg, cmd_data} <= {1'b1, nm, r, d};
      {cmd_src, exec_busy, cmd_op, cmd_loc} <= {sb, o, l};
      cmd_thread <= ~cmd_thread;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1 {w, p} = {rf_wr_en, pb_wr_en};
      @(posedge clk);
      #1 {a, n} = {ack, nak};
   endtask
   task t_imm;
      // host sends command 11 while busy
      issue(8'h0B, 16'h2, 32'h8000_0000, 2'h1);
      `CHK({w, a, n, rf_wr_data}, {3'b110, 32'h8000_0000})
      `CHK(cmd_ready, 1'b1)
   endtask
   task t_prog;
      issue(8'h9A, 16'h4, 32'h1, 2'h1);
      `CHK({w, a, n}, 3'b001)
      issue(8'h9A, 16'h4, 32'hFFFF_FFFF, 2'h3);
      `CHK({w, a, rf_wr_data}, {2'b11, 32'hFFFF_FFFF})
      issue(8'h9A, 16'h5, 32'h7FFF_FFFF);
      `CHK({w, a, rf_wr_addr}, {2'b11, 16'h5})
      // unknown number: no write, reject only
      issue(8'hFF, 16'h5, 32'h0);
      `CHK({w, p, a, n}, 4'h1)
   endtask
   task t_mod;
      logic [31:0] v, d;
      {v, d} = {32'hFFFF_FFF0, 32'h0F0F_00F1};
      issue(8'h0B, 16'h3, v);
      for (int i = 0; i < 6; i++)
      begin
         case (i)
            0: v = v | d;
            1: v = v & ~d;
            2: v = v & d;
            3: v = v ^ d;
            4: v = v + d;
         endcase
         issue(8'h1E, 16'h3, d, 2'h0, i[2:0]);
         `CHK({w, a, n, rf_wr_data}, {i < 5, i < 5, i == 5, v})
         d = {d[23:0], d[31:24]};
      end
   endtask
   task t_patch;
      issue(8'h0B, 16'h6, 32'h1234_FFFE);
      issue(8'h8B, 16'h6, 32'h0, 2'h3, 3'h0, 16'h0FFF);
      `CHK({p, w, a}, 3'h5)
      `CHK({pb_wr_addr, pb_wr_data}, {16'h0FFF, 16'hFFFE})
   endtask
   task test_done;
      if (n_mismatch == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      forever #2 clk = ~clk;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      `CHK({ack, nak, pb_wr_en}, 3'b000)
      t_imm;
      t_prog;
      t_mod;
      t_patch;
      test_done;
   end
endmodule // test_register_write_command_exec
bind register_write_command_exec register_write_command_exec_sva u_sva (
   .clk, .rstn, .cmd_valid, .cmd_src, .cmd_num, .cmd_op, .cmd_data,
   .exec_busy, .rf_rd_data, .rf_wr_en, .rf_wr_data, .pb_wr_en, .pb_wr_data,
   .ack, .nak);
